/* File: common/fbp_map.svh */
`ifndef FBP_MAP_SVH
`define FBP_MAP_SVH
`define FBP_CFG_CP_LO 22'h300008
`define FBP_CFG_CP_HI 22'h300009
`define FBP_CFG_WP_LO 22'h30000a
`define FBP_CFG_WP_HI 22'h30000b
`define FBP_CFG_RP_LO 22'h30000c
`define FBP_CFG_RP_HI 22'h30000d
`define FBP_BIT_EE 7
`define FBP_BIT_BOOT 6
`define FBP_BIT_CFG 5
`define FBP_BOOT_END_SMALL 17'h001ff
`define FBP_BOOT_END_LARGE 17'h007ff
`define FBP_B0_END_8K 17'h00fff
`define FBP_B0_END_MID 17'h01fff
`define FBP_B0_END_64K 17'h03fff
`define FBP_B1_END_8K 17'h01fff
`define FBP_B1_END_MID 17'h03fff
`define FBP_B1_END_64K 17'h07fff
`define FBP_B2_END_32K 17'h05fff
`define FBP_B2_END_64K 17'h0bfff
`define FBP_B3_END_32K 17'h07fff
`define FBP_B3_END_64K 17'h0ffff
`define FBP_MEM_END_8K 17'h01fff
`define FBP_MEM_END_16K 17'h03fff
`define FBP_MEM_END_32K 17'h07fff
`define FBP_MEM_END_64K 17'h0ffff
`define FBP_ERASED 8'hff
`define FBP_ZERO 8'h00
`endif

/* File: common/fbp_pkg.sv */
package fbp_pkg;
  typedef enum logic [1:0] {
    FBP_SIZE_8K,
    FBP_SIZE_16K,
    FBP_SIZE_32K,
    FBP_SIZE_64K
  } fbp_size_t;
  typedef enum logic [2:0] {
    FBP_BLK_BOOT,
    FBP_BLK_0,
    FBP_BLK_1,
    FBP_BLK_2,
    FBP_BLK_3,
    FBP_BLK_NONE
  } fbp_blk_t;
  typedef enum logic [1:0] {
    FBP_IDLE,
    FBP_ANSWER
  } fbp_state_t;
endpackage

/* File: common/fbp_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fbp_dec_if;
  import fbp_pkg::*;
  logic [21:0] addr;
  fbp_blk_t blk;
  modport decoder (input addr, output blk);
  modport user (output addr, input blk);
endinterface
`default_nettype wire

/* File: core/fbp_block_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"
module fbp_block_decode
  import fbp_pkg::*;
(
  // configuration
  input wire fbp_size_t size,
  // lookup
  fbp_dec_if.decoder dec
);
  logic [16:0] a;
  logic hi_zero;
  assign hi_zero = (dec.addr[21:17] == 5'h00);
  assign a = dec.addr[16:0];
  always_comb begin
    dec.blk = FBP_BLK_NONE;
    if (hi_zero) begin
      case (size)
        FBP_SIZE_8K: begin
          if (a <= `FBP_BOOT_END_SMALL) dec.blk = FBP_BLK_BOOT;
          else if (a <= `FBP_B0_END_8K) dec.blk = FBP_BLK_0;
          else if (a <= `FBP_B1_END_8K) dec.blk = FBP_BLK_1;
        end
        FBP_SIZE_16K, FBP_SIZE_32K: begin
          if (a <= `FBP_BOOT_END_LARGE) dec.blk = FBP_BLK_BOOT;
          else if (a <= `FBP_B0_END_MID) dec.blk = FBP_BLK_0;
          else if (a <= `FBP_B1_END_MID) dec.blk = FBP_BLK_1;
          else if (size == FBP_SIZE_32K && a <= `FBP_B2_END_32K)
            dec.blk = FBP_BLK_2;
          else if (size == FBP_SIZE_32K && a <= `FBP_B3_END_32K)
            dec.blk = FBP_BLK_3;
        end
        FBP_SIZE_64K: begin
          if (a <= `FBP_BOOT_END_LARGE) dec.blk = FBP_BLK_BOOT;
          else if (a <= `FBP_B0_END_64K) dec.blk = FBP_BLK_0;
          else if (a <= `FBP_B1_END_64K) dec.blk = FBP_BLK_1;
          else if (a <= `FBP_B2_END_64K) dec.blk = FBP_BLK_2;
          else if (a <= `FBP_B3_END_64K) dec.blk = FBP_BLK_3;
        end
        default: dec.blk = FBP_BLK_NONE;
      endcase
    end
  end
endmodule // fbp_block_decode
`default_nettype wire

/* File: core/fbp_prot_bits.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"
module fbp_prot_bits #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // update
  input wire logic clr_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic erase,
  input wire logic [WIDTH-1:0] erase_mask,
  // state
  output logic [WIDTH-1:0] bits
);
  logic [WIDTH-1:0] bits_q;
  logic [WIDTH-1:0] bits_d;
  always_comb begin
    bits_d = bits_q;
    if (clr_en) bits_d = bits_d & wdata;
    if (erase) bits_d = bits_d | erase_mask;
    bits_d = bits_d & IMPL;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) bits_q <= IMPL;
    else bits_q <= bits_d;
  end
  assign bits = bits_q;
endmodule // fbp_prot_bits
`default_nettype wire

/* File: core/fbp_protect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_map.svh"
module fbp_protect
  import fbp_pkg::*;
#(
  parameter fbp_size_t MEM_SIZE = FBP_SIZE_32K
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // cpu table access
  input wire logic TBL_REQ,
  input wire logic TBL_WRITE,
  input wire logic [21:0] TBL_ADDR,
  input wire logic [21:0] TBL_PC,
  input wire logic [7:0] TBL_WDATA,
  input wire logic [7:0] MEM_RDATA,
  output logic TBL_ACK,
  output logic [7:0] TBL_RDATA,
  output logic TBL_WR_EN,
  output logic TBL_REJECT,
  // external programmer
  input wire logic EXT_REQ,
  input wire logic EXT_WRITE,
  input wire logic [21:0] EXT_ADDR,
  input wire logic CHIP_ERASE,
  input wire logic BLOCK_ERASE,
  input wire logic [2:0] ERASE_BLOCK,
  output logic EXT_ACK,
  output logic EXT_WR_EN,
  output logic EXT_REJECT,
  output logic [7:0] EXT_RDATA,
  // protection state
  output logic [5:0] EXT_READ_PROT_N,
  output logic EEPROM_CODE_PROT_N,
  output logic EEPROM_WRITE_PROT_N
);
  fbp_dec_if dec_tgt();
  fbp_dec_if dec_src();
  fbp_dec_if dec_ext();
  fbp_size_t size;
  fbp_blk_t tgt_blk, src_blk, ext_blk;
  logic [7:0] cp_lo, cp_hi, wp_lo, wp_hi, rp_lo, rp_hi;
  logic [7:0] lo_erase, boot_erase;
  logic erase_any, is_cfg, cfg_wr_ok;
  logic wr_cp_lo, wr_cp_hi, wr_wp_lo, wr_wp_hi, wr_rp_lo, wr_rp_hi;
  logic [7:0] cfg_rdata;
  logic tgt_rp_n, tgt_wp_n, ext_cp_n, ext_valid, read_ok;
  fbp_state_t state_q;
  logic tbl_ack_q, tbl_wr_en_q, tbl_reject_q;
  logic ext_ack_q, ext_wr_en_q, ext_reject_q;
  logic [7:0] tbl_rdata_q, ext_rdata_q;
  logic [5:0] rp_out_q;
  logic ee_cp_q, ee_wp_q;

  assign size = MEM_SIZE;
  assign dec_tgt.addr = TBL_ADDR;
  assign dec_src.addr = TBL_PC;
  assign dec_ext.addr = EXT_ADDR;
  assign tgt_blk = dec_tgt.blk;
  assign src_blk = dec_src.blk;
  assign ext_blk = dec_ext.blk;

  fbp_block_decode u_dec_tgt (.size(size), .dec(dec_tgt));
  fbp_block_decode u_dec_src (.size(size), .dec(dec_src));
  fbp_block_decode u_dec_ext (.size(size), .dec(dec_ext));

  assign is_cfg = (TBL_ADDR >= `FBP_CFG_CP_LO) &&
    (TBL_ADDR <= `FBP_CFG_RP_HI);
  // config writes gated by the config write-protect bit
  assign cfg_wr_ok = TBL_REQ && TBL_WRITE && wp_hi[`FBP_BIT_CFG];
  assign wr_cp_lo = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_CP_LO);
  assign wr_cp_hi = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_CP_HI);
  assign wr_wp_lo = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_WP_LO);
  assign wr_wp_hi = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_WP_HI);
  assign wr_rp_lo = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_RP_LO);
  assign wr_rp_hi = cfg_wr_ok && (TBL_ADDR == `FBP_CFG_RP_HI);

  assign erase_any = CHIP_ERASE || BLOCK_ERASE;
  always_comb begin
    lo_erase = `FBP_ZERO;
    boot_erase = `FBP_ZERO;
    if (CHIP_ERASE) begin
      lo_erase = `FBP_ERASED;
      boot_erase = `FBP_ERASED;
    end else if (BLOCK_ERASE) begin
      case (fbp_blk_t'(ERASE_BLOCK))
        FBP_BLK_BOOT: boot_erase[`FBP_BIT_BOOT] = 1'b1;
        FBP_BLK_0: lo_erase[0] = 1'b1;
        FBP_BLK_1: lo_erase[1] = 1'b1;
        FBP_BLK_2: lo_erase[2] = 1'b1;
        FBP_BLK_3: lo_erase[3] = 1'b1;
        default: lo_erase = `FBP_ZERO;
      endcase
    end
  end

  fbp_prot_bits #(.WIDTH(8), .IMPL(8'h0f)) u_cp_lo (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_cp_lo), .wdata(TBL_WDATA),
    .erase(erase_any), .erase_mask(lo_erase), .bits(cp_lo));
  fbp_prot_bits #(.WIDTH(8), .IMPL(8'hc0)) u_cp_hi (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_cp_hi), .wdata(TBL_WDATA),
    .erase(erase_any), .erase_mask(boot_erase | (CHIP_ERASE ?
    `FBP_ERASED : `FBP_ZERO)), .bits(cp_hi));
  fbp_prot_bits #(.WIDTH(8), .IMPL(8'h0f)) u_wp_lo (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_wp_lo), .wdata(TBL_WDATA),
    .erase(erase_any), .erase_mask(lo_erase), .bits(wp_lo));
  // config write-protect is read-only from the table path
  fbp_prot_bits #(.WIDTH(8), .IMPL(8'he0)) u_wp_hi (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_wp_hi),
    .wdata(TBL_WDATA | 8'h20), .erase(erase_any),
    .erase_mask(boot_erase), .bits(wp_hi));
  fbp_prot_bits #(.WIDTH(8), .IMPL(8'h0f)) u_rp_lo (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_rp_lo), .wdata(TBL_WDATA),
    .erase(erase_any), .erase_mask(lo_erase), .bits(rp_lo));
  fbp_prot_bits #(.WIDTH(8), .IMPL(8'h40)) u_rp_hi (.clk(CORE_CLK),
    .rst_n(RESET_N), .clr_en(wr_rp_hi), .wdata(TBL_WDATA),
    .erase(erase_any), .erase_mask(boot_erase), .bits(rp_hi));

  always_comb begin
    case (TBL_ADDR)
      `FBP_CFG_CP_LO: cfg_rdata = cp_lo;
      `FBP_CFG_CP_HI: cfg_rdata = cp_hi;
      `FBP_CFG_WP_LO: cfg_rdata = wp_lo;
      `FBP_CFG_WP_HI: cfg_rdata = wp_hi;
      `FBP_CFG_RP_LO: cfg_rdata = rp_lo;
      `FBP_CFG_RP_HI: cfg_rdata = rp_hi;
      default: cfg_rdata = `FBP_ZERO;
    endcase
  end

  always_comb begin
    tgt_rp_n = 1'b1;
    tgt_wp_n = 1'b0;
    case (tgt_blk)
      FBP_BLK_BOOT: begin
        tgt_rp_n = rp_hi[`FBP_BIT_BOOT];
        tgt_wp_n = wp_hi[`FBP_BIT_BOOT];
      end
      FBP_BLK_0: begin
        tgt_rp_n = rp_lo[0];
        tgt_wp_n = wp_lo[0];
      end
      FBP_BLK_1: begin
        tgt_rp_n = rp_lo[1];
        tgt_wp_n = wp_lo[1];
      end
      FBP_BLK_2: begin
        tgt_rp_n = rp_lo[2];
        tgt_wp_n = wp_lo[2];
      end
      FBP_BLK_3: begin
        tgt_rp_n = rp_lo[3];
        tgt_wp_n = wp_lo[3];
      end
      default: begin
        tgt_rp_n = 1'b1;
        tgt_wp_n = 1'b0;
      end
    endcase
  end

  always_comb begin
    ext_valid = 1'b1;
    case (ext_blk)
      FBP_BLK_BOOT: ext_cp_n = cp_hi[`FBP_BIT_BOOT];
      FBP_BLK_0: ext_cp_n = cp_lo[0];
      FBP_BLK_1: ext_cp_n = cp_lo[1];
      FBP_BLK_2: ext_cp_n = cp_lo[2];
      FBP_BLK_3: ext_cp_n = cp_lo[3];
      default: begin
        ext_cp_n = 1'b0;
        ext_valid = 1'b0;
      end
    endcase
  end

  assign read_ok = (tgt_blk != FBP_BLK_NONE) &&
    (tgt_rp_n || (tgt_blk == src_blk));

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) state_q <= FBP_IDLE;
    else begin
      case (state_q)
        FBP_IDLE: if (TBL_REQ) state_q <= FBP_ANSWER;
        FBP_ANSWER: state_q <= TBL_REQ ? FBP_ANSWER : FBP_IDLE;
        default: state_q <= FBP_IDLE;
      endcase
    end
  end

  // table path answer
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      tbl_ack_q <= 1'b0;
      tbl_wr_en_q <= 1'b0;
      tbl_reject_q <= 1'b0;
      tbl_rdata_q <= `FBP_ZERO;
    end else begin
      tbl_ack_q <= TBL_REQ;
      tbl_wr_en_q <= 1'b0;
      tbl_reject_q <= 1'b0;
      tbl_rdata_q <= `FBP_ZERO;
      if (TBL_REQ && TBL_WRITE) begin
        tbl_wr_en_q <= !is_cfg && tgt_wp_n;
        tbl_reject_q <= is_cfg ? !wp_hi[`FBP_BIT_CFG] : !tgt_wp_n;
      end else if (TBL_REQ) begin
        if (is_cfg) tbl_rdata_q <= cfg_rdata;
        else if (read_ok) tbl_rdata_q <= MEM_RDATA;
        tbl_reject_q <= !is_cfg && !read_ok;
      end
    end
  end

  // programmer path answer
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ext_ack_q <= 1'b0;
      ext_wr_en_q <= 1'b0;
      ext_reject_q <= 1'b0;
      ext_rdata_q <= `FBP_ZERO;
    end else begin
      ext_ack_q <= EXT_REQ;
      ext_wr_en_q <= EXT_REQ && EXT_WRITE && ext_valid && ext_cp_n;
      ext_reject_q <= EXT_REQ && !(ext_valid && ext_cp_n);
      ext_rdata_q <= (EXT_REQ && !EXT_WRITE && ext_valid && ext_cp_n) ?
        MEM_RDATA : `FBP_ZERO;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rp_out_q <= 6'h2f;
      ee_cp_q <= 1'b1;
      ee_wp_q <= 1'b1;
    end else begin
      rp_out_q <= {rp_hi[`FBP_BIT_BOOT], 1'b0, rp_lo[3:0]};
      ee_cp_q <= cp_hi[`FBP_BIT_EE];
      ee_wp_q <= wp_hi[`FBP_BIT_EE];
    end
  end

  assign TBL_ACK = tbl_ack_q;
  assign TBL_RDATA = tbl_rdata_q;
  assign TBL_WR_EN = tbl_wr_en_q;
  assign TBL_REJECT = tbl_reject_q;
  assign EXT_ACK = ext_ack_q;
  assign EXT_WR_EN = ext_wr_en_q;
  assign EXT_REJECT = ext_reject_q;
  assign EXT_RDATA = ext_rdata_q;
  assign EXT_READ_PROT_N = rp_out_q;
  assign EEPROM_CODE_PROT_N = ee_cp_q;
  assign EEPROM_WRITE_PROT_N = ee_wp_q;
endmodule // fbp_protect
`default_nettype wire

/* File: sim/fbp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model (
  // lookup
  input wire logic [21:0] addr,
  // flash byte
  output logic [7:0] rdata
);
  // byte pattern keyed on address
  assign rdata = addr[7:0] ^ 8'ha5;
endmodule // fbp_flash_model
`default_nettype wire

/* File: sim/fbp_protect_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module fbp_protect_asserts
  import fbp_pkg::*;
#(
  parameter fbp_size_t MEM_SIZE = FBP_SIZE_32K
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // table side
  input wire logic TBL_REQ,
  input wire logic TBL_WRITE,
  input wire logic [21:0] TBL_ADDR,
  input wire logic [21:0] TBL_PC,
  input wire logic [7:0] MEM_RDATA,
  input wire logic TBL_ACK,
  input wire logic [7:0] TBL_RDATA,
  input wire logic TBL_WR_EN,
  input wire logic TBL_REJECT,
  // programmer side
  input wire logic EXT_REQ,
  input wire logic EXT_ACK,
  input wire logic CHIP_ERASE,
  input wire logic BLOCK_ERASE,
  input wire logic [5:0] EXT_READ_PROT_N
);
  logic erase_any;
  assign erase_any = CHIP_ERASE | BLOCK_ERASE;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);
  tbl_ack_a:
    assert property (TBL_REQ |=> TBL_ACK) else $error("table ack missing");
  ext_ack_a:
    assert property (EXT_REQ |=> EXT_ACK) else $error("ext ack missing");
  blk_zero_a:
    assert property (TBL_ACK && (TBL_REJECT || $past(TBL_WRITE))
      |-> TBL_RDATA == 8'h00) else $error("refused read not zero");
  rd_pass_a:
    assert property (TBL_ACK && !TBL_REJECT && !$past(TBL_WRITE)
      && $past(TBL_ADDR) < 22'h010000 |-> TBL_RDATA == $past(MEM_RDATA))
      else $error("read data not passed");
  wr_cause_a:
    assert property (TBL_WR_EN |-> !TBL_REJECT && $past(TBL_REQ)
      && $past(TBL_WRITE)) else $error("stray write enable");
  unmap_a:
    assert property (TBL_REQ && TBL_ADDR >= 22'h010000
      && TBL_ADDR < 22'h300000 |=> TBL_REJECT) else $error("unmapped ok");
  boot_rp_a:
    assert property (TBL_REQ && !TBL_WRITE && TBL_ADDR < 22'h000200
      && TBL_PC[21:11] == 11'h001 && !EXT_READ_PROT_N[5] |=> TBL_REJECT)
      else $error("boot read not blocked");
  rsv_zero_a:
    assert property (EXT_READ_PROT_N[4] == 1'b0) else $error("reserved set");
  erase_set_a:
    assert property (CHIP_ERASE |-> ##[1:2] EXT_READ_PROT_N == 6'h2f)
      else $error("chip erase not applied");
  clr_only_a:
    assert property ((EXT_READ_PROT_N & ~$past(EXT_READ_PROT_N)) != 6'h00
      |-> $past(erase_any) || $past(erase_any, 2))
      else $error("bit set without erase");
endmodule // fbp_protect_asserts
bind fbp_protect fbp_protect_asserts #(.MEM_SIZE(MEM_SIZE)) u_chk (.*);
`default_nettype wire

/* File: sim/tb_flash_block_code_protection.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_block_code_protection;
  import fbp_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [21:0] addr;
    logic [21:0] pc;
    logic [7:0] wd;
    logic [1:0] res;
    logic [7:0] rd;
  } fbp_row_t;
  logic CORE_CLK, RESET_N = 1'b0;
  logic TBL_REQ = 1'b0, TBL_WRITE = 1'b0, EXT_REQ = 1'b0, EXT_WRITE = 1'b0;
  logic [21:0] TBL_ADDR = 22'h0, TBL_PC = 22'h0, EXT_ADDR = 22'h0;
  logic [7:0] TBL_WDATA = 8'h00, MEM_RDATA, TBL_RDATA, EXT_RDATA;
  logic CHIP_ERASE = 1'b0, BLOCK_ERASE = 1'b0;
  logic [2:0] ERASE_BLOCK = 3'h0;
  logic TBL_ACK, TBL_WR_EN, TBL_REJECT, EXT_ACK, EXT_WR_EN, EXT_REJECT;
  logic [5:0] EXT_READ_PROT_N;
  logic EEPROM_CODE_PROT_N, EEPROM_WRITE_PROT_N;
  logic [21:0] mem_addr;
  int bad_count = 0, checks = 0, cycles = 0;
  // op 0 read, 1 write, 2 programmer read; res {reject, write enable}
  fbp_row_t rows [20] = '{
    '{2'h0, 22'h002010, 22'h000900, 8'h00, 2'h0, 8'hb5},
    '{2'h1, 22'h002010, 22'h000900, 8'h00, 2'h1, 8'h00},
    '{2'h1, 22'h30000c, 22'h0, 8'hfd, 2'h0, 8'h00},
    '{2'h0, 22'h30000c, 22'h0, 8'h00, 2'h0, 8'h0d},
    '{2'h1, 22'h30000c, 22'h0, 8'hff, 2'h0, 8'h00},
    '{2'h0, 22'h30000c, 22'h0, 8'h00, 2'h0, 8'h0d},
    '{2'h0, 22'h002010, 22'h000900, 8'h00, 2'h2, 8'h00},
    '{2'h0, 22'h002010, 22'h002100, 8'h00, 2'h0, 8'hb5},
    '{2'h1, 22'h30000d, 22'h0, 8'hbf, 2'h0, 8'h00},
    '{2'h0, 22'h000010, 22'h000900, 8'h00, 2'h2, 8'h00},
    '{2'h0, 22'h000010, 22'h000100, 8'h00, 2'h0, 8'hb5},
    '{2'h1, 22'h30000a, 22'h0, 8'hfe, 2'h0, 8'h00},
    '{2'h1, 22'h000900, 22'h002000, 8'h00, 2'h2, 8'h00},
    '{2'h0, 22'h008000, 22'h000100, 8'h00, 2'h2, 8'h00},
    '{2'h1, 22'h300008, 22'h0, 8'hfe, 2'h0, 8'h00},
    '{2'h2, 22'h000900, 22'h0, 8'h00, 2'h2, 8'h00},
    '{2'h2, 22'h002010, 22'h0, 8'h00, 2'h0, 8'hb5},
    '{2'h0, 22'h000900, 22'h000a00, 8'h00, 2'h0, 8'ha5},
    '{2'h1, 22'h30000b, 22'h0, 8'h00, 2'h0, 8'h00},
    '{2'h0, 22'h30000b, 22'h0, 8'h00, 2'h0, 8'h20}};
  logic [7:0] rst_v [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
  assign mem_addr = EXT_REQ ? EXT_ADDR : TBL_ADDR;
  fbp_flash_model u_mem (.addr(mem_addr), .rdata(MEM_RDATA));
  fbp_protect #(.MEM_SIZE(FBP_SIZE_32K)) DUT (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input fbp_row_t r);
    TBL_REQ <= (r.op != 2'h2);
    EXT_REQ <= (r.op == 2'h2);
    TBL_WRITE <= r.op[0];
    TBL_ADDR <= r.addr;
    EXT_ADDR <= r.addr;
    TBL_PC <= r.pc;
    TBL_WDATA <= r.wd;
    @(posedge CORE_CLK);
    #2;
    TBL_REQ <= 1'b0;
    EXT_REQ <= 1'b0;
    if (r.op[1])
      chk({EXT_ACK, EXT_REJECT, EXT_WR_EN, EXT_RDATA}, {1'b1, r.res, r.rd});
    else
      chk({TBL_ACK, TBL_REJECT, TBL_WR_EN, TBL_RDATA}, {1'b1, r.res, r.rd});
    @(posedge CORE_CLK);
    #2;
  endtask
  task automatic pulse(input logic chip, input logic [2:0] blk);
    CHIP_ERASE <= chip;
    BLOCK_ERASE <= !chip;
    ERASE_BLOCK <= blk;
    @(posedge CORE_CLK);
    #2;
    CHIP_ERASE <= 1'b0;
    BLOCK_ERASE <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #2;
  endtask
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge CORE_CLK);
    #2;
    RESET_N <= 1'b1;
    chk(11'(EXT_READ_PROT_N), 11'h02f);
    chk(11'({EEPROM_CODE_PROT_N, EEPROM_WRITE_PROT_N}), 11'h003);
    for (int i = 0; i < 6; i++)
      acc('{2'h0, 22'h300008 + 22'(i), 22'h0, 8'h00, 2'h0, rst_v[i]});
    foreach (rows[i]) acc(rows[i]);
    chk(11'(EXT_READ_PROT_N), 11'h00d);
    chk(11'(EEPROM_WRITE_PROT_N), 11'h000);
    pulse(1'b0, 3'h2);
    chk(11'(EXT_READ_PROT_N), 11'h00f);
    pulse(1'b1, 3'h0);
    chk(11'(EXT_READ_PROT_N), 11'h02f);
    acc('{2'h0, 22'h300008, 22'h0, 8'h00, 2'h0, 8'h0f});
    acc('{2'h1, 22'h30000c, 22'h0, 8'hfe, 2'h0, 8'h00});
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    #2;
    RESET_N <= 1'b1;
    chk(11'(EXT_READ_PROT_N), 11'h02f);
    summarize();
  end
endmodule // tb_flash_block_code_protection
`default_nettype wire
